// >>> design/flash_front_pkg.sv
package flash_front_pkg;

  // array geometry, byte address of the full 4 MB array
  localparam int ADDR_W = 24;
  localparam int SECTOR_LSB = 12;
  localparam int HALF_BLOCK_LSB = 15;
  localparam int BLOCK_LSB = 16;
  localparam int ARRAY_MSB = 21;
  localparam int SECTOR_W = 10;
  localparam int HALF_BLOCK_W = 7;
  localparam int BLOCK_W = 6;
  localparam logic [1:0] ADDR_BYTES_LAST = 2'h2;

  // lane counts per serial clock
  localparam logic [3:0] LANES_1 = 4'h1;
  localparam logic [3:0] LANES_2 = 4'h2;
  localparam logic [3:0] LANES_4 = 4'h4;
  localparam logic [3:0] BITS_PER_BYTE = 4'h8;

  // opcodes
  localparam logic [7:0] OP_READ = 8'h03;
  localparam logic [7:0] OP_FAST_READ = 8'h0b;
  localparam logic [7:0] OP_PAGE_PROG = 8'h02;
  localparam logic [7:0] OP_SECTOR_ERASE = 8'h20;
  localparam logic [7:0] OP_HALF_BLOCK_ERASE = 8'h52;
  localparam logic [7:0] OP_BLOCK_ERASE = 8'hd8;
  localparam logic [7:0] OP_DUAL_OUT_READ = 8'h3b;
  localparam logic [7:0] OP_DUAL_IO_READ = 8'hbb;
  localparam logic [7:0] OP_DUAL_ID_READ = 8'h92;
  localparam logic [7:0] OP_QUAD_OUT_READ = 8'h6b;
  localparam logic [7:0] OP_QUAD_IO_READ = 8'heb;
  localparam logic [7:0] OP_QUAD_WORD_READ = 8'he7;
  localparam logic [7:0] OP_QUAD_ID_READ = 8'h94;
  localparam logic [7:0] OP_QUAD_PAGE_PROG = 8'h32;

  // reset values
  localparam logic [7:0] BYTE_RST = 8'h00;
  localparam logic [3:0] NIBBLE_RST = 4'h0;

  // transfer phase, one-hot
  typedef enum logic [3:0] {
    PH_OPC = 4'b0001,
    PH_ADDR = 4'b0010,
    PH_DATA = 4'b0100,
    PH_IGNORE = 4'b1000
  } phase_t;

endpackage

// >>> design/flash_front.sv
// Operation
// - address space split into 1024 uniform 4 KB sectors, last at 3FF000h.
// - sixteen sectors form one 64 KB block, blocks 0 to 63.
// - eight sectors form one 32 KB half block, half blocks 0 to 127.
// - works with serial clock idling low or high (modes 0 and 3).
// - inputs sampled on rising clock edges, outputs change after falling edges.
// - dual output, dual io and dual id reads move two bits per clock.
// - in dual transfers lines 0 and 1 are bidirectional data.
// - quad reads, quad id read and quad page program move four bits.
// - in quad transfers lines 0 to 3 all carry data.
// - quad opcodes run only when quad enable bit is set.
// - after power-up a select falling edge is needed before selection.
// - ignore everything until power-on reset releases, then start clean.
// - reasserted power-on reset stops all response.
// - select low means active; select high without write means standby.
// - during pause the outputs float and clock and input are ignored.
// - pause freezes the transfer and resumes at the same bit.
// - pause starts when pause input falls with serial clock low.
// - pause ends when pause input rises with serial clock low.
// - select going high during pause resets the interface.
// - pause change while clock high waits until clock goes low.
// - pause only works with quad enable clear; else line 3 is data.
// - with select high all inputs ignored and outputs float.
// - pause never stops a running internal write, program or erase.
`timescale 1ns/10ps
module flash_front
  import flash_front_pkg::*;
(
  input wire logic clk,
  input wire logic nrst,
  input wire logic sclk,
  input wire logic csN,
  input wire logic [3:0] ioIn,
  output logic [3:0] ioOut,
  output logic [3:0] ioOe,
  input wire logic quadEnableBit,
  input wire logic writeBusy,
  input wire logic [7:0] txByte,
  output logic txReq,
  output logic [7:0] opcode,
  output logic opValid,
  output logic [23:0] address,
  output logic addrValid,
  output logic [9:0] sectorNum,
  output logic [6:0] halfBlockNum,
  output logic [5:0] blockNum,
  output logic addrInRange,
  output logic [7:0] rxByte,
  output logic rxValid,
  output logic paused,
  output logic active,
  output logic standby
);

  // lanes used while the address is shifted in
  function automatic logic [3:0] addrLanes(input logic [7:0] op);
    if (op == OP_DUAL_IO_READ || op == OP_DUAL_ID_READ) begin
      addrLanes = LANES_2;
    end else if (op == OP_QUAD_IO_READ || op == OP_QUAD_WORD_READ || op == OP_QUAD_ID_READ) begin
      addrLanes = LANES_4;
    end else begin
      addrLanes = LANES_1;
    end
  endfunction
  // lanes used in the data phase
  function automatic logic [3:0] dataLanes(input logic [7:0] op);
    if (op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ || op == OP_DUAL_ID_READ) begin
      dataLanes = LANES_2;
    end else if (op == OP_QUAD_OUT_READ || op == OP_QUAD_IO_READ || op == OP_QUAD_WORD_READ ||
                 op == OP_QUAD_ID_READ || op == OP_QUAD_PAGE_PROG) begin
      dataLanes = LANES_4;
    end else begin
      dataLanes = LANES_1;
    end
  endfunction
  function automatic logic isQuad(input logic [7:0] op);
    isQuad = (dataLanes(op) == LANES_4);
  endfunction
  function automatic logic isRead(input logic [7:0] op);
    isRead = (op == OP_READ || op == OP_FAST_READ || op == OP_DUAL_OUT_READ || op == OP_DUAL_IO_READ ||
              op == OP_DUAL_ID_READ || op == OP_QUAD_OUT_READ || op == OP_QUAD_IO_READ ||
              op == OP_QUAD_WORD_READ || op == OP_QUAD_ID_READ);
  endfunction
  function automatic logic needsAddr(input logic [7:0] op);
    needsAddr = isRead(op) || op == OP_PAGE_PROG || op == OP_QUAD_PAGE_PROG ||
                op == OP_SECTOR_ERASE || op == OP_HALF_BLOCK_ERASE || op == OP_BLOCK_ERASE;
  endfunction

  logic sclkMeta, sclkSync, sclkDly;
  logic csMeta, csSync, csDly;
  logic [3:0] ioMeta, ioSync;
  logic sclkRise, sclkFall, csFall, go;
  logic armed_reg, selected_reg, paused_reg;
  phase_t phase_reg;
  logic [3:0] bitCnt_reg;
  logic [1:0] addrCnt_reg;
  logic [7:0] shiftIn_reg, txShift_reg;
  logic [3:0] lanes;
  logic [7:0] shiftIn_next;
  logic byteDone, readData;

  // two-stage synchronisers on every pin plus edge history on clock and select; the first stage feeds only the second
  // select flops reset low: a reset value of high would arm the part before the pin was ever seen high
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sclkMeta <= 1'b0;
      sclkSync <= 1'b0;
      sclkDly <= 1'b0;
      csMeta <= 1'b0;
      csSync <= 1'b0;
      csDly <= 1'b0;
      ioMeta <= NIBBLE_RST;
      ioSync <= NIBBLE_RST;
    end else begin
      sclkMeta <= sclk;
      sclkSync <= sclkMeta;
      sclkDly <= sclkSync;
      csMeta <= csN;
      csSync <= csMeta;
      csDly <= csSync;
      ioMeta <= ioIn;
      ioSync <= ioMeta;
    end
  end

  // edges work the same whatever level the clock idles at
  assign sclkRise = sclkSync & ~sclkDly;
  assign sclkFall = ~sclkSync & sclkDly;
  assign csFall = ~csSync & csDly;
  // pause and deselect both mask the serial clock
  assign go = selected_reg & ~csSync & ~paused_reg;

  // select high must be seen once after reset, so a select already low is not taken
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      armed_reg <= 1'b0;
    end else if (csSync) begin
      armed_reg <= 1'b1;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      selected_reg <= 1'b0;
    end else if (csSync) begin
      selected_reg <= 1'b0;
    end else if (csFall && armed_reg) begin
      selected_reg <= 1'b1;
    end
  end

  // pause tracks the pause pin only while the clock is low, so a change with it high waits; deselect drops it
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      paused_reg <= 1'b0;
    end else if (!selected_reg || csSync || quadEnableBit) begin
      paused_reg <= 1'b0;
    end else if (!sclkSync) begin
      paused_reg <= ~ioSync[3];
    end
  end

  // lane count of the current phase
  always_comb begin
    lanes = LANES_1;
    readData = 1'b0;
    if (phase_reg == PH_ADDR) begin
      lanes = addrLanes(opcode);
    end else if (phase_reg == PH_DATA) begin
      lanes = dataLanes(opcode);
      readData = isRead(opcode);
    end
  end

  // bits enter at the bottom, so the first bit ends up most significant
  always_comb begin
    shiftIn_next = {shiftIn_reg[6:0], ioSync[0]};
    if (lanes == LANES_2) begin
      shiftIn_next = {shiftIn_reg[5:0], ioSync[1], ioSync[0]};
    end else if (lanes == LANES_4) begin
      shiftIn_next = {shiftIn_reg[3:0], ioSync[3], ioSync[2], ioSync[1], ioSync[0]};
    end
  end

  assign byteDone = (bitCnt_reg + lanes) == BITS_PER_BYTE;

  // bit position; frozen while paused so the transfer picks up where it stopped
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      bitCnt_reg <= NIBBLE_RST;
      shiftIn_reg <= BYTE_RST;
    end else if (csSync) begin
      bitCnt_reg <= NIBBLE_RST;
    end else if (go && sclkRise) begin
      shiftIn_reg <= shiftIn_next;
      bitCnt_reg <= byteDone ? NIBBLE_RST : bitCnt_reg + lanes;
    end
  end

  // phase sequence: opcode, address, then data until select rises
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      phase_reg <= PH_OPC;
      addrCnt_reg <= 2'h0;
    end else if (csSync) begin
      phase_reg <= PH_OPC;
      addrCnt_reg <= 2'h0;
    end else if (go && sclkRise && byteDone) begin
      case (phase_reg)
        PH_OPC: begin
          if (isQuad(shiftIn_next) && !quadEnableBit) begin
            phase_reg <= PH_IGNORE;
          end else if (needsAddr(shiftIn_next)) begin
            phase_reg <= PH_ADDR;
          end else begin
            phase_reg <= PH_DATA;
          end
        end
        PH_ADDR: begin
          addrCnt_reg <= addrCnt_reg + 2'h1;
          if (addrCnt_reg == ADDR_BYTES_LAST) begin
            phase_reg <= PH_DATA;
          end
        end
        default: begin
          phase_reg <= phase_reg;
        end
      endcase
    end
  end

  // captured opcode and address, with one-cycle strobes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      opcode <= BYTE_RST;
      opValid <= 1'b0;
      address <= '0;
      addrValid <= 1'b0;
    end else begin
      opValid <= go && sclkRise && byteDone && phase_reg == PH_OPC;
      addrValid <= go && sclkRise && byteDone && phase_reg == PH_ADDR && addrCnt_reg == ADDR_BYTES_LAST;
      if (go && sclkRise && byteDone && phase_reg == PH_OPC) begin
        opcode <= shiftIn_next;
      end
      if (go && sclkRise && byteDone && phase_reg == PH_ADDR) begin
        address <= {address[15:0], shiftIn_next};
      end
    end
  end

  // sector, half block and block numbers of the received address
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      sectorNum <= '0;
      halfBlockNum <= '0;
      blockNum <= '0;
      addrInRange <= 1'b0;
    end else begin
      sectorNum <= address[ARRAY_MSB:SECTOR_LSB];
      halfBlockNum <= address[ARRAY_MSB:HALF_BLOCK_LSB];
      blockNum <= address[ARRAY_MSB:BLOCK_LSB];
      addrInRange <= address[ADDR_W-1:ARRAY_MSB+1] == 2'h0;
    end
  end

  // write data bytes; read opcodes give no received bytes
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      rxByte <= BYTE_RST;
      rxValid <= 1'b0;
    end else begin
      rxValid <= go && sclkRise && byteDone && phase_reg == PH_DATA && !readData;
      if (go && sclkRise && byteDone && phase_reg == PH_DATA) begin
        rxByte <= shiftIn_next;
      end
    end
  end

  // read bytes load at each byte boundary and leave on falling edges
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      txShift_reg <= BYTE_RST;
      txReq <= 1'b0;
    end else begin
      txReq <= 1'b0;
      if (go && sclkRise && byteDone && isRead(opcode) &&
          (phase_reg == PH_DATA || (phase_reg == PH_ADDR && addrCnt_reg == ADDR_BYTES_LAST))) begin
        txShift_reg <= txByte;
        txReq <= 1'b1;
      end else if (go && sclkFall && readData) begin
        txShift_reg <= txShift_reg << lanes;
      end
    end
  end

  // pin values change only after a falling edge; enables come on after the rise that opens the data phase and drop at once on pause or deselect
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      ioOut <= NIBBLE_RST;
      ioOe <= NIBBLE_RST;
    end else begin
      if (!go || !readData) begin
        ioOe <= NIBBLE_RST;
      end else if (lanes == LANES_4) begin
        ioOe <= 4'hf;
      end else if (lanes == LANES_2) begin
        ioOe <= 4'h3;
      end else begin
        ioOe <= 4'h2;
      end
      if (go && sclkFall && readData) begin
        if (lanes == LANES_4) begin
          ioOut <= txShift_reg[7:4];
        end else if (lanes == LANES_2) begin
          ioOut <= {2'h0, txShift_reg[7:6]};
        end else begin
          ioOut <= {2'h0, txShift_reg[7], 1'b0};
        end
      end
    end
  end

  // power state; a running internal write keeps the part out of standby even when paused
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      active <= 1'b0;
      standby <= 1'b1;
      paused <= 1'b0;
    end else begin
      active <= selected_reg;
      standby <= csSync && !writeBusy;
      paused <= paused_reg;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  hiz_deselect_a: assert property (csSync |=> ioOe == NIBBLE_RST)
    else $error("outputs driven while deselected");
  pause_hiz_a: assert property (paused_reg |=> ioOe == NIBBLE_RST)
    else $error("outputs driven during pause");
  pause_freeze_a: assert property (paused_reg && !csSync |=> $stable(bitCnt_reg) && $stable(phase_reg))
    else $error("transfer moved during pause");
  pause_enter_a: assert property (selected_reg && !csSync && !quadEnableBit && !sclkSync && !ioSync[3]
    |=> paused_reg)
    else $error("pause not entered with clock low");
  pause_wait_a: assert property (selected_reg && !csSync && !quadEnableBit && sclkSync
    |=> $stable(paused_reg))
    else $error("pause changed while clock high");
  pause_exit_a: assert property (paused_reg && !csSync && !quadEnableBit && !sclkSync && ioSync[3]
    |=> !paused_reg)
    else $error("pause not left with clock low");
  first_select_a: assert property (!armed_reg |-> !selected_reg)
    else $error("selected without a select falling edge");
  quad_block_a: assert property (opValid && isQuad(opcode) && !$past(quadEnableBit)
    |-> phase_reg == PH_IGNORE)
    else $error("quad opcode run with quad enable clear");
  deselect_abort_a: assert property (csSync |=> phase_reg == PH_OPC && bitCnt_reg == NIBBLE_RST)
    else $error("interface not reset on deselect");
  quad_nopause_a: assert property (quadEnableBit |=> !paused_reg)
    else $error("pause honoured with quad enable set");
  standby_a: assert property (csSync && !writeBusy |=> standby)
    else $error("standby not entered");
  read_byte_c: cover property (txReq ##[1:200] txReq);
  pause_seen_c: cover property (paused_reg ##[1:100] !paused_reg && selected_reg);
  quad_prog_c: cover property (rxValid && opcode == OP_QUAD_PAGE_PROG);
  addr_taken_c: cover property (addrValid && addrLanes(opcode) == LANES_4);

endmodule

// >>> dv/spi_host_model.sv
`timescale 1ns/10ps
// behavioural host controller; every sclk, csN and host-driven line change lands on a falling clk edge
module spi_host_model (
  input wire logic clk,
  input wire logic [3:0] ioOut,
  input wire logic [3:0] ioOe,
  output logic sclk,
  output logic csN,
  output logic [3:0] ioIn
);
  logic [3:0] hostOe = 4'hf;
  logic [3:0] hostVal = 4'hc;
  logic [3:0] oeSeen = 4'h0;
  logic flip = 1'b0;
  logic mode3 = 1'b0;
  // select starts low so a select already low at power-up gets tried
  initial begin
    sclk = 1'b0;
    csN = 1'b0;
  end
  // a released line 0 or 1 wobbles every cycle, lines 2 and 3 have pull-ups
  always @(posedge clk) flip <= ~flip;
  always_comb begin
    for (int l = 0; l < 4; l++) begin
      ioIn[l] = ioOe[l] ? ioOut[l] : hostOe[l] ? hostVal[l] : (l > 1) ? 1'b1 : flip;
    end
  end
  task automatic tick(input int n);
    repeat (n) @(negedge clk);
  endtask
  // select goes high first so every frame opens with a falling select edge
  task automatic start(input logic m3);
    mode3 = m3;
    csN = 1'b1;
    sclk = m3;
    tick(4);
    csN = 1'b0;
    tick(4);
  endtask
  // mode 0 parks the clock low before deselect, mode 3 leaves it high
  task automatic stop();
    sclk = mode3;
    tick(4);
    csN = 1'b1;
    hostOe = 4'hf;
    hostVal = 4'hc;
    tick(8);
  endtask
  // drive in the low phase, sample just before the rise; msb group first
  task automatic shift(input int lanes, input int cyc, input logic [31:0] val, input logic rd,
                       output logic [31:0] got);
    int ln;
    got = 32'h0;
    for (int c = cyc - 1; c >= 0; c--) begin
      sclk = 1'b0;
      for (int l = 0; l < lanes; l++) begin
        ln = (rd && lanes == 1) ? 1 : l;
        hostOe[ln] = ~rd;
        hostVal[ln] = val[c * lanes + l];
      end
      tick(4);
      for (int l = 0; l < lanes; l++) begin
        got[c * lanes + l] = ioIn[(rd && lanes == 1) ? 1 : l];
      end
      oeSeen = ioOe;
      sclk = 1'b1;
      tick(4);
    end
  endtask
  // pause pin level; lowClk parks the clock low first
  task automatic hold_pin(input logic v, input logic lowClk);
    if (lowClk) sclk = 1'b0;
    hostVal[3] = v;
    tick(8);
  endtask
endmodule

// >>> dv/flash_front_tb.sv
`timescale 1ns/10ps
module flash_front_tb
  import flash_front_pkg::*;
;
  logic clk = 1'b0;
  logic nrst = 1'b0;
  logic quadEnableBit = 1'b0;
  logic writeBusy = 1'b0;
  logic [7:0] txByte = 8'h00;
  logic sclk, csN, txReq, opValid, addrValid, addrInRange, rxValid, paused, active, standby;
  logic [3:0] ioIn, ioOut, ioOe;
  logic [7:0] opcode, rxByte, rd8;
  logic [23:0] address;
  logic [9:0] sectorNum;
  logic [6:0] halfBlockNum;
  logic [5:0] blockNum;
  logic [7:0] opQ[$];
  logic [7:0] rxQ[$];
  logic [23:0] adQ[$];
  logic [23:0] geoAddr = 24'h0;
  logic [1:0] geoDly = 2'h0;
  logic [31:0] got;
  logic [7:0] opList [14] = '{OP_READ, OP_FAST_READ, OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_DUAL_ID_READ,
    OP_QUAD_OUT_READ, OP_QUAD_IO_READ, OP_QUAD_WORD_READ, OP_QUAD_ID_READ, OP_PAGE_PROG, OP_QUAD_PAGE_PROG,
    OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE};
  int bad_count = 0;
  int tests_run = 0;
  int seed = 8087;
  int cycles = 0;
  int txCount = 0;

  always #5 clk = ~clk;

  flash_front dut (.clk(clk), .nrst(nrst), .sclk(sclk), .csN(csN), .ioIn(ioIn), .ioOut(ioOut), .ioOe(ioOe),
    .quadEnableBit(quadEnableBit), .writeBusy(writeBusy), .txByte(txByte), .txReq(txReq), .opcode(opcode),
    .opValid(opValid), .address(address), .addrValid(addrValid), .sectorNum(sectorNum),
    .halfBlockNum(halfBlockNum), .blockNum(blockNum), .addrInRange(addrInRange), .rxByte(rxByte),
    .rxValid(rxValid), .paused(paused), .active(active), .standby(standby));
  spi_host_model host (.clk(clk), .ioOut(ioOut), .ioOe(ioOe), .sclk(sclk), .csN(csN), .ioIn(ioIn));

  task automatic chk_val(input string nm, input logic [23:0] e, input logic [23:0] g);
    tests_run++;
    if (g !== e) begin
      bad_count++;
      $display("[ERR] %s expected %h seen %h", nm, e, g);
    end
  endtask
  // a strobe with nothing noted for it, or a hang
  task automatic chk_evt(input string nm);
    tests_run++;
    bad_count++;
    $display("[ERR] %s expected none seen one", nm);
  endtask
  task automatic wrap_up();
    $display("checks %0d mismatches %0d", tests_run, bad_count);
    if (bad_count == 0 && tests_run > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  // strobes pop the oldest note; geometry is read two cycles after the address
  always @(posedge clk) begin
    cycles++;
    if (txReq) txCount++;
    geoDly <= {geoDly[0], addrValid};
    if (opValid) begin
      if (opQ.size() == 0) chk_evt("opcode");
      else chk_val("opcode", 24'(opQ.pop_front()), 24'(opcode));
    end
    if (addrValid) begin
      if (adQ.size() == 0) chk_evt("address");
      else begin
        geoAddr <= adQ[0];
        chk_val("address", adQ.pop_front(), address);
      end
    end
    if (geoDly[1]) chk_val("geometry", {geoAddr[21:12], geoAddr[21:15], geoAddr[21:16], geoAddr[23:22] == 2'h0},
      {sectorNum, halfBlockNum, blockNum, addrInRange});
    if (rxValid) begin
      if (rxQ.size() == 0) chk_evt("rxByte");
      else chk_val("rxByte", 24'(rxQ.pop_front()), 24'(rxByte));
    end
    if (cycles > 40000) begin
      chk_evt("timeout");
      wrap_up();
    end
  end

  // one whole operation; a quad opcode without the enable bit gets only its opcode seen
  task automatic frame(input logic [7:0] op, input logic m3);
    int al;
    int dl;
    logic [23:0] a;
    logic [7:0] d;
    logic ok;
    logic rdOp;
    int t0;
    al = (op inside {OP_DUAL_IO_READ, OP_DUAL_ID_READ}) ? 2 :
      (op inside {OP_QUAD_IO_READ, OP_QUAD_WORD_READ, OP_QUAD_ID_READ}) ? 4 : 1;
    dl = (op inside {OP_DUAL_OUT_READ, OP_DUAL_IO_READ, OP_DUAL_ID_READ}) ? 2 : (op inside {OP_QUAD_OUT_READ,
      OP_QUAD_IO_READ, OP_QUAD_WORD_READ, OP_QUAD_ID_READ, OP_QUAD_PAGE_PROG}) ? 4 : 1;
    ok = quadEnableBit || dl != 4;
    rdOp = !(op inside {OP_PAGE_PROG, OP_QUAD_PAGE_PROG, OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE});
    a = 24'($random(seed));
    if (op == OP_SECTOR_ERASE) a[23:12] = 12'h3ff;
    d = 8'($random(seed));
    txByte = d;
    writeBusy = 1'($random(seed));
    t0 = txCount;
    host.start(m3);
    opQ.push_back(op);
    host.shift(1, 8, 32'(op), 1'b0, got);
    chk_val("activeStandby", 24'h2, 24'({active, standby}));
    if (ok) adQ.push_back(a);
    host.shift(al, 24 / al, 32'(a), 1'b0, got);
    if (op inside {OP_PAGE_PROG, OP_QUAD_PAGE_PROG}) begin
      if (ok) rxQ.push_back(d);
      if (ok) rxQ.push_back(~d);
      host.shift(dl, 16 / dl, 32'({d, ~d}), 1'b0, got);
    end else if (!(op inside {OP_SECTOR_ERASE, OP_HALF_BLOCK_ERASE, OP_BLOCK_ERASE})) begin
      host.shift(dl, 8 / dl, 32'h0, 1'b1, got);
      if (ok) chk_val("readData", 24'(d), got[23:0]);
      if (ok) chk_val("readOe", 24'(dl == 1 ? 4'h2 : dl == 2 ? 4'h3 : 4'hf), 24'(host.oeSeen));
    end
    host.stop();
    chk_val("idle", 24'({4'h0, 1'b0, ~writeBusy}), 24'({ioOe, active, standby}));
    // a taken read asks for one byte at the address end and one after its eight data bits
    chk_val("txReq", (ok && rdOp) ? 24'h2 : 24'h0, 24'(txCount - t0));
  endtask

  initial begin
    repeat (16) @(negedge clk);
    chk_val("resetState", 24'h1, 24'({ioOe, opValid, active, standby}));
    nrst = 1'b1;
    // select already low at release: this opcode must go unseen
    host.shift(1, 8, 32'(OP_READ), 1'b0, got);
    host.stop();
    // reset dropping mid-frame silences the device until a fresh select
    host.start(1'b0);
    host.shift(1, 4, 32'h0, 1'b0, got);
    nrst = 1'b0;
    host.shift(1, 12, 32'(OP_PAGE_PROG), 1'b0, got);
    nrst = 1'b1;
    host.shift(1, 8, 32'(OP_PAGE_PROG), 1'b0, got);
    host.stop();
    quadEnableBit = 1'b1;
    foreach (opList[i]) frame(opList[i], 1'(i));
    quadEnableBit = 1'b0;
    frame(OP_QUAD_IO_READ, 1'b0);
    frame(OP_QUAD_PAGE_PROG, 1'b1);
    frame(OP_DUAL_IO_READ, 1'b1);
    // with the enable bit set the pause pin is plain data
    quadEnableBit = 1'b1;
    host.start(1'b0);
    opQ.push_back(OP_PAGE_PROG);
    host.shift(1, 8, 32'(OP_PAGE_PROG), 1'b0, got);
    host.hold_pin(1'b0, 1'b1);
    chk_val("paused", 24'h0, 24'(paused));
    host.stop();
    quadEnableBit = 1'b0;
    // a pause asked for with the clock high waits for the clock to drop
    host.start(1'b0);
    opQ.push_back(OP_FAST_READ);
    host.shift(1, 8, 32'(OP_FAST_READ), 1'b0, got);
    host.hold_pin(1'b0, 1'b0);
    chk_val("paused", 24'h0, 24'(paused));
    host.hold_pin(1'b0, 1'b1);
    chk_val("paused", 24'h1, 24'(paused));
    host.stop();
    chk_val("paused", 24'h0, 24'(paused));
    // pause in mid-byte of a read with the clock waved, then resume
    txByte = 8'($random(seed));
    host.start(1'b0);
    opQ.push_back(OP_READ);
    adQ.push_back(24'h3ff100);
    host.shift(1, 8, 32'(OP_READ), 1'b0, got);
    host.shift(1, 24, 32'h3ff100, 1'b0, got);
    host.shift(1, 4, 32'h0, 1'b1, got);
    rd8[7:4] = got[3:0];
    host.hold_pin(1'b1, 1'b1);
    host.hold_pin(1'b0, 1'b1);
    chk_val("pauseOe", 24'h10, 24'({paused, ioOe}));
    host.shift(1, 3, 32'($random(seed)), 1'b0, got);
    host.hold_pin(1'b0, 1'b1);
    host.hold_pin(1'b1, 1'b1);
    chk_val("paused", 24'h0, 24'(paused));
    host.shift(1, 4, 32'h0, 1'b1, got);
    rd8[3:0] = got[3:0];
    chk_val("resumed", 24'(txByte), 24'(rd8));
    host.stop();
    wrap_up();
  end
endmodule
